// ---- pss_pkg.sv ----
// Purpose: constants and carriers of the pulse-skip / bridge / shutdown PWM block
// Assumes: AHB-Lite register access, 32-bit words, one clock
// Notes:   register offsets are byte addresses
package pss_pkg;
   // ==========================================
   // register map
   localparam logic [7:0] PSS_OFS_CLK   = 8'h00;
   localparam logic [7:0] PSS_OFS_OEN   = 8'h04;
   localparam logic [7:0] PSS_OFS_PRS   = 8'h08;
   localparam logic [7:0] PSS_OFS_MODE  = 8'h0c;
   localparam logic [7:0] PSS_OFS_ASDC  = 8'h10;
   localparam logic [7:0] PSS_OFS_ASDS  = 8'h14;
   localparam logic [7:0] PSS_OFS_ASDL  = 8'h18;
   localparam logic [7:0] PSS_OFS_PH    = 8'h1c;
   localparam logic [7:0] PSS_OFS_PR    = 8'h20;
   localparam logic [7:0] PSS_OFS_DB    = 8'h24;
   localparam logic [7:0] PSS_OFS_STAT  = 8'h28;
   // ==========================================
   // field layout and reset values
   localparam logic [7:0] PSS_CLK_MASK  = 8'h33;
   localparam logic [7:0] PSS_OEN_MASK  = 8'h3f;
   localparam logic [7:0] PSS_PRS_MASK  = 8'h9f;
   localparam int         PSS_PRS_IN    = 7;
   localparam int         PSS_PRS_TM    = 0;
   localparam int         PSS_ASDC_EN   = 7;
   localparam int         PSS_ASDC_FLG  = 6;
   localparam int         PSS_ASDC_OV   = 5;
   localparam int         PSS_ASDC_ARS  = 4;
   localparam logic [7:0] PSS_RST8      = 8'h00;
   localparam logic [15:0] PSS_RST16    = 16'h0000;
   // ==========================================
   // modes
   typedef enum logic [1:0] {
      PSS_MODE_OFF  = 2'b00,
      PSS_MODE_SKIP = 2'b01,
      PSS_MODE_FWD  = 2'b10,
      PSS_MODE_REV  = 2'b11
   } pss_mode_t;
   typedef enum logic [1:0] {
      PSS_DIR_RUN   = 2'b00,
      PSS_DIR_DBF   = 2'b01,
      PSS_DIR_DBR   = 2'b10
   } pss_dir_t;
   // ==========================================
   // ahb request carrier
   typedef struct packed {
      logic        sel;
      logic        wr;
      logic [7:0]  addr;
   } pss_ahb_req_t;
endpackage

// ---- pss_top.sv ----
// Purpose: pulse-skip, bridge and shutdown PWM with AHB-Lite registers
// Assumes: ref_clk 50 MHz; all event inputs asynchronous to ref_clk
// Notes:   osc and pll clock sources arrive as enable pulses from outside, the external pin as a level
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module pss_top #(
   parameter int TB_W = 16
) (
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   // ahb-lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic [31:0]            hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   // module clock candidates: osc and pll as one-cycle enables, external pin as a level
   input  wire logic              osc_clk_en,
   input  wire logic              pll_clk_en,
   input  wire logic              external_clock_pin,
   // event inputs
   input  wire logic              event_input_pin,
   input  wire logic [3:0]        comparator_sync_out,
   input  wire logic [3:0]        rise_src,
   input  wire logic [3:0]        fall_src,
   input  wire logic [3:0]        shutdown_src,
   // power stage pins
   output logic [5:0]             pwm_out,
   output logic [5:0]             pwm_oe,
   output logic                   shutdown_irq
);
   // ==========================================
   // state
   typedef struct packed {
      logic [3:0]           clk_sync1;
      logic [3:0]           clk_sync2;
      logic [13:0]          in_s1;
      logic [13:0]          in_s2;
      logic                 pin_clk_d;
      logic [2:0]           pre_cnt;
      logic [7:0]           clk_ctl;
      logic [7:0]           oen;
      logic [7:0]           prs;
      pss_pkg::pss_mode_t   mode;
      logic [7:0]           asdc;
      logic [3:0]           asds;
      logic [5:0]           asdl;
      logic [TB_W-1:0]      phase;
      logic [TB_W-1:0]      period;
      logic [7:0]           db_rise;
      logic [7:0]           db_fall;
      logic [TB_W-1:0]      tmr;
      logic [5:0]           prs_prev;
      logic                 qualified;
      logic                 out_a;
      logic                 out_b;
      logic                 dir_rev;
      pss_pkg::pss_dir_t    dir_st;
      logic [7:0]           db_cnt;
      logic                 halted;
      pss_pkg::pss_ahb_req_t req;
      logic [31:0]          rdata;
      logic [5:0]           pins;
      logic [5:0]           pins_oe;
      logic                 irq;
   } pss_state_t;

   pss_state_t s_q;
   pss_state_t s_d;

   // ==========================================
   // combinational helpers
   logic              tick;
   logic              src_tick;
   logic              pin_clk_s;
   logic [5:0]        prs_now;
   logic              period_ev;
   logic              rise_ev;
   logic              fall_ev;
   logic              ext_sd;
   logic              sd_cond;
   logic              override;
   logic [5:0]        run_pins;
   logic [7:0]        wdat;
   logic              wr_go;

   always_comb begin
      s_d       = s_q;
      wdat      = hwdata[7:0];
      wr_go     = s_q.req.sel && s_q.req.wr;
      // input synchronisers, second stage only is read
      s_d.in_s1 = {external_clock_pin, event_input_pin, comparator_sync_out,
                   rise_src, fall_src};
      s_d.in_s2 = s_q.in_s1;
      s_d.clk_sync1 = {shutdown_src};
      s_d.clk_sync2 = s_q.clk_sync1;
      pin_clk_s = s_q.in_s2[13];
      s_d.pin_clk_d = pin_clk_s;
      // clock source select
      case (s_q.clk_ctl[1:0])
         2'b00:   src_tick = osc_clk_en;
         2'b01:   src_tick = pll_clk_en;
         2'b10:   src_tick = pin_clk_s && !s_q.pin_clk_d;
         default: src_tick = 1'b0;
      endcase
      // prescaler
      tick = 1'b0;
      if (src_tick) begin
         s_d.pre_cnt = s_q.pre_cnt + 3'd1;
         case (s_q.clk_ctl[5:4])
            2'b11:   tick = (s_q.pre_cnt == 3'd7);
            2'b10:   tick = (s_q.pre_cnt[1:0] == 2'd3);
            2'b01:   tick = s_q.pre_cnt[0];
            default: tick = 1'b1;
         endcase
      end
      // period sources, OR of rising enabled sources
      prs_now = {s_q.in_s2[12], s_q.in_s2[11:8],
                 (s_q.tmr == s_q.period)};
      period_ev = 1'b0;
      if (tick) begin
         s_d.prs_prev = prs_now;
         period_ev = |({s_q.prs[pss_pkg::PSS_PRS_IN], s_q.prs[4:1], s_q.prs[0]}
                       & prs_now & ~s_q.prs_prev);
         s_d.tmr = period_ev ? '0 : s_q.tmr + 1'b1;
      end
      // waveform events
      rise_ev = tick && (s_q.tmr == s_q.phase);
      fall_ev = tick && |s_q.in_s2[3:0];
      // shutdown
      ext_sd   = s_q.asdc[pss_pkg::PSS_ASDC_EN] && |(s_q.clk_sync2 & s_q.asds);
      s_d.irq  = 1'b0;
      if (wr_go && s_q.req.addr == pss_pkg::PSS_OFS_ASDC) begin
         s_d.asdc = wdat;
         if (!wdat[pss_pkg::PSS_ASDC_FLG] && ext_sd)
            s_d.asdc[pss_pkg::PSS_ASDC_FLG] = 1'b1;
         if (wdat[pss_pkg::PSS_ASDC_FLG] && wdat[pss_pkg::PSS_ASDC_EN]
             && !s_q.asdc[pss_pkg::PSS_ASDC_FLG])
            s_d.irq = 1'b1;
      end
      if (ext_sd) begin
         if (!s_q.asdc[pss_pkg::PSS_ASDC_FLG])
            s_d.irq = 1'b1;
         s_d.asdc[pss_pkg::PSS_ASDC_FLG] = 1'b1;
      end else if (s_q.asdc[pss_pkg::PSS_ASDC_ARS] && s_q.asdc[pss_pkg::PSS_ASDC_EN]
                   && |s_q.asds && !(wr_go && s_q.req.addr == pss_pkg::PSS_OFS_ASDC)) begin
         s_d.asdc[pss_pkg::PSS_ASDC_FLG] = 1'b0;
      end
      sd_cond  = s_q.asdc[pss_pkg::PSS_ASDC_EN] && s_q.asdc[pss_pkg::PSS_ASDC_FLG];
      override = s_q.asdc[pss_pkg::PSS_ASDC_EN] &&
                 (sd_cond || s_q.asdc[pss_pkg::PSS_ASDC_OV]);
      if (sd_cond)
         s_d.halted = 1'b1;
      else if (period_ev)
         s_d.halted = 1'b0;
      // pulse-skipping qualification
      if (period_ev)
         s_d.qualified = |s_q.in_s2[7:4];
      else if (rise_ev)
         s_d.qualified = 1'b0;
      // direction and deadband
      case (s_q.dir_st)
         pss_pkg::PSS_DIR_RUN: begin
            if ((s_q.mode == pss_pkg::PSS_MODE_REV) != s_q.dir_rev &&
                (s_q.mode == pss_pkg::PSS_MODE_FWD || s_q.mode == pss_pkg::PSS_MODE_REV)) begin
               s_d.dir_rev = !s_q.dir_rev;
               s_d.db_cnt  = s_q.dir_rev ? s_q.db_rise : s_q.db_fall;
               s_d.dir_st  = s_q.dir_rev ? pss_pkg::PSS_DIR_DBR : pss_pkg::PSS_DIR_DBF;
               s_d.out_a   = 1'b0;
               s_d.out_b   = 1'b0;
            end
         end
         pss_pkg::PSS_DIR_DBF, pss_pkg::PSS_DIR_DBR: begin
            if (s_q.db_cnt == 8'h00)
               s_d.dir_st = pss_pkg::PSS_DIR_RUN;
            else if (tick)
               s_d.db_cnt = s_q.db_cnt - 8'd1;
         end
         default: s_d.dir_st = pss_pkg::PSS_DIR_RUN;
      endcase
      if (s_q.dir_st == pss_pkg::PSS_DIR_RUN) begin
         case (s_q.mode)
            pss_pkg::PSS_MODE_SKIP: begin
               if (fall_ev)
                  s_d.out_a = 1'b0;
               else if (rise_ev && s_q.qualified)
                  s_d.out_a = 1'b1;
               s_d.out_b = 1'b0;
            end
            pss_pkg::PSS_MODE_FWD: begin
               if (fall_ev)
                  s_d.out_a = 1'b0;
               else if (rise_ev)
                  s_d.out_a = 1'b1;
               s_d.out_b = 1'b0;
            end
            pss_pkg::PSS_MODE_REV: begin
               if (fall_ev)
                  s_d.out_b = 1'b0;
               else if (rise_ev)
                  s_d.out_b = 1'b1;
               s_d.out_a = 1'b0;
            end
            default: begin
               s_d.out_a = 1'b0;
               s_d.out_b = 1'b0;
            end
         endcase
      end
      // pin assembly
      run_pins = 6'h00;
      run_pins[0] = s_q.out_a;
      if (s_q.mode == pss_pkg::PSS_MODE_FWD || s_q.mode == pss_pkg::PSS_MODE_REV) begin
         run_pins[1] = s_q.out_b;
         run_pins[2] = s_q.dir_st == pss_pkg::PSS_DIR_RUN && s_q.dir_rev;
         run_pins[3] = s_q.dir_st == pss_pkg::PSS_DIR_RUN && !s_q.dir_rev;
      end
      if (s_q.halted && !sd_cond)
         run_pins = 6'h00;
      s_d.pins    = override ? s_q.asdl : run_pins;
      s_d.pins_oe = s_q.oen[5:0];
      // ahb-lite address phase
      s_d.req.sel  = hsel && hready && htrans[1];
      s_d.req.wr   = hwrite;
      s_d.req.addr = haddr[7:0];
      if (wr_go) begin
         case (s_q.req.addr)
            pss_pkg::PSS_OFS_CLK:  s_d.clk_ctl = wdat & pss_pkg::PSS_CLK_MASK;
            pss_pkg::PSS_OFS_OEN:  s_d.oen     = wdat & pss_pkg::PSS_OEN_MASK;
            pss_pkg::PSS_OFS_PRS:  s_d.prs     = wdat & pss_pkg::PSS_PRS_MASK;
            pss_pkg::PSS_OFS_MODE: s_d.mode    = pss_pkg::pss_mode_t'(wdat[1:0]);
            pss_pkg::PSS_OFS_ASDS: s_d.asds    = wdat[3:0];
            pss_pkg::PSS_OFS_ASDL: s_d.asdl    = wdat[5:0];
            pss_pkg::PSS_OFS_PH:   s_d.phase   = hwdata[TB_W-1:0];
            pss_pkg::PSS_OFS_PR:   s_d.period  = hwdata[TB_W-1:0];
            pss_pkg::PSS_OFS_DB:   {s_d.db_fall, s_d.db_rise} = hwdata[15:0];
            default: ;
         endcase
      end
      // read data for the next data phase
      s_d.rdata = 32'h0000_0000;
      if (s_d.req.sel && !hwrite) begin
         case (haddr[7:0])
            pss_pkg::PSS_OFS_CLK:  s_d.rdata[7:0]  = s_q.clk_ctl;
            pss_pkg::PSS_OFS_OEN:  s_d.rdata[7:0]  = s_q.oen;
            pss_pkg::PSS_OFS_PRS:  s_d.rdata[7:0]  = s_q.prs;
            pss_pkg::PSS_OFS_MODE: s_d.rdata[1:0]  = s_q.mode;
            pss_pkg::PSS_OFS_ASDC: s_d.rdata[7:0]  = s_d.asdc;
            pss_pkg::PSS_OFS_ASDS: s_d.rdata[3:0]  = s_q.asds;
            pss_pkg::PSS_OFS_ASDL: s_d.rdata[5:0]  = s_q.asdl;
            pss_pkg::PSS_OFS_PH:   s_d.rdata[TB_W-1:0] = s_q.phase;
            pss_pkg::PSS_OFS_PR:   s_d.rdata[TB_W-1:0] = s_q.period;
            pss_pkg::PSS_OFS_DB:   s_d.rdata[15:0] = {s_q.db_fall, s_q.db_rise};
            pss_pkg::PSS_OFS_STAT: s_d.rdata[TB_W+7:0] = {s_q.tmr, 2'b00,
                                    s_q.pins};
            default: ;
         endcase
      end
   end

   // ==========================================
   // state register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================
   // outputs
   assign hrdata       = s_q.rdata;
   assign hreadyout    = 1'b1;
   assign hresp        = 1'b0;
   assign pwm_out      = s_q.pins;
   assign pwm_oe       = s_q.pins_oe;
   assign shutdown_irq = s_q.irq;
endmodule // pss_top

// ---- pss_partner.sv ----
// Purpose: far-side model giving the three module clock sources
// Assumes: one ref_clk domain
// Notes:   pll at half rate, external pin period of six cycles
`timescale 1ns/1ps
module pss_partner (
   // clock
   input  wire logic ref_clk,
   // module clock sources
   output logic      osc_clk_en,
   output logic      pll_clk_en,
   output logic      external_clock_pin
);
   logic [1:0] div_q = 2'h0;
   initial osc_clk_en = 1'b1;
   initial pll_clk_en = 1'b0;
   initial external_clock_pin = 1'b0;
   // ==========================================
   // source generation
   always @(posedge ref_clk) begin
      pll_clk_en <= ~pll_clk_en;
      div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
      if (div_q == 2'h2) begin
         external_clock_pin <= ~external_clock_pin;
      end
   end
endmodule // pss_partner

// ---- pss_top_assertions.sv ----
// Purpose: port checker for pss_top
// Assumes: register values shadowed from bus writes
// Notes:   bound to pss_top below
`timescale 1ns/1ps
module pss_chk #(
   parameter int TB_W = 16
) (
   // watched ports
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [3:0]  shutdown_src,
   input wire logic [5:0]  pwm_out,
   input wire logic [5:0]  pwm_oe,
   input wire logic        shutdown_irq
);
   logic       av_q, aw_q;
   logic [7:0] aa_q, md_q, pm_q, sc_q, ss_q, sl_q, oe_q;
   logic [5:0] age_q;
   logic [1:0] mg_q;
   // ==========================================
   // register shadow
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         {av_q, aw_q, aa_q, md_q, pm_q, sc_q, ss_q, sl_q, oe_q, age_q, mg_q} <= '0;
      end else begin
         av_q <= hsel && hready && htrans[1];
         aw_q <= hwrite;
         aa_q <= haddr[7:0];
         age_q <= (age_q == 6'h3f) ? age_q : age_q + 6'h01;
         mg_q <= (mg_q == 2'h3) ? mg_q : mg_q + 2'h1;
         if (av_q && aw_q && aa_q == pss_pkg::PSS_OFS_MODE) begin
            md_q <= hwdata[7:0];
            pm_q <= md_q;
            age_q <= 6'h00;
            mg_q <= 2'h0;
         end
         if (av_q && aw_q && aa_q == pss_pkg::PSS_OFS_ASDC) begin
            sc_q <= hwdata[7:0];
            age_q <= 6'h00;
         end
         if (av_q && aw_q && aa_q == pss_pkg::PSS_OFS_ASDS) ss_q <= hwdata[7:0];
         if (av_q && aw_q && aa_q == pss_pkg::PSS_OFS_ASDL) sl_q <= hwdata[7:0];
         if (av_q && aw_q && aa_q == pss_pkg::PSS_OFS_OEN) oe_q <= hwdata[7:0];
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // assertions
   AST_FWD_PINS: assert property (md_q[1:0] == 2'b10 && !sc_q[7] && age_q > 6'd40
      |-> pwm_out[3:1] == 3'b100) else $error("forward static pins wrong");
   AST_REV_PINS: assert property (md_q[1:0] == 2'b11 && !sc_q[7] && age_q > 6'd40
      |-> pwm_out[3:2] == 2'b01 && !pwm_out[0]) else $error("reverse static pins wrong");
   AST_SKIP_ONLY_A: assert property (md_q[1:0] == 2'b01 && !sc_q[7] && age_q > 6'd40
      |-> pwm_out[5:1] == 5'h00) else $error("skip mode drives other pins");
   AST_DB_TO_REV: assert property (md_q[1:0] == 2'b11 && pm_q[1:0] == 2'b10 && mg_q < 2'h3
      |-> !pwm_out[2]) else $error("no dead band into reverse");
   AST_DB_TO_FWD: assert property (md_q[1:0] == 2'b10 && pm_q[1:0] == 2'b11 && mg_q < 2'h3
      |-> !pwm_out[3]) else $error("no dead band into forward");
   AST_SD_LEVEL: assert property ((sc_q[7] && |(shutdown_src & ss_q[3:0])) [*6]
      |-> pwm_out[3:0] == sl_q[3:0]) else $error("shutdown levels not driven");
   AST_OVR_LEVEL: assert property (sc_q[7] && sc_q[5] && age_q > 6'd3
      |-> pwm_out[3:0] == sl_q[3:0]) else $error("override levels not driven");
   AST_IRQ_GATED: assert property (shutdown_irq |-> sc_q[7] || $past(sc_q[7]))
      else $error("interrupt while shutdown disabled");
   AST_IRQ_PULSE: assert property (shutdown_irq |=> !shutdown_irq)
      else $error("interrupt longer than one cycle");
   AST_OE_REG: assert property ($stable(oe_q) [*2] |-> pwm_oe == oe_q[5:0])
      else $error("output enables differ from register");
endmodule // pss_chk
bind pss_top pss_chk #(.TB_W(TB_W)) u_chk (.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
   .hwdata, .hready, .shutdown_src, .pwm_out, .pwm_oe, .shutdown_irq);

// ---- tb_top.sv ----
// Purpose: self-checking bench of pss_top
// Assumes: module tick on every ref_clk cycle from the partner
// Notes:   bus master per ahb-lite single word transfers
`timescale 1ns/1ps
module tb_top;
   logic        ref_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, event_input_pin = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, rd, hrdata;
   logic [1:0]  htrans = '0;
   logic [2:0]  hsize = 3'h2;
   logic [3:0]  comparator_sync_out = '0, rise_src = '0, fall_src = '0, shutdown_src = '0;
   logic        hreadyout, hresp, osc_clk_en, pll_clk_en, external_clock_pin, shutdown_irq, s;
   logic [5:0]  pwm_out, pwm_oe;
   wire logic   hready = hreadyout;
   int          fails = 0, check_count = 0, irqs = 0, n;
   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (shutdown_irq === 1'b1) irqs++;
   pss_partner u_far (.ref_clk, .osc_clk_en, .pll_clk_en, .external_clock_pin);
   pss_top #(.TB_W(16)) uut (.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hrdata, .hreadyout, .hresp, .osc_clk_en, .pll_clk_en, .external_clock_pin,
      .event_input_pin, .comparator_sync_out, .rise_src, .fall_src, .shutdown_src, .pwm_out,
      .pwm_oe, .shutdown_irq);
   // ==========================================
   // shared tasks
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge ref_clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge ref_clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic pin(input int c);
      repeat (c) @(negedge ref_clk);
   endtask
   task automatic wait_pin(input int b, input logic v);
      s = 1'b0;
      repeat (60) begin
         @(negedge ref_clk);
         if (pwm_out[b] === v) s = 1'b1;
      end
      chk(32'(s), 32'h1);
   endtask
   // ==========================================
   // scenarios
   task automatic t_regs;
      logic [7:0] m [3];
      m = '{pss_pkg::PSS_CLK_MASK, pss_pkg::PSS_OEN_MASK, pss_pkg::PSS_PRS_MASK};
      for (int i = 0; i < 3; i++) begin
         bus(1'b0, 8'(4 * i), 32'h0);
         chk(rd, 32'h0);
         bus(1'b1, 8'(4 * i), 32'hffff_ffff);
         bus(1'b0, 8'(4 * i), 32'h0);
         chk(rd, {24'h0, m[i]});
      end
      pin(2);
      chk({26'h0, pwm_oe}, 32'h3f);
      bus(1'b1, 8'h3c, 32'hffff_ffff);
      bus(1'b0, 8'h3c, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, pss_pkg::PSS_OFS_OEN, 32'h0);
   endtask
   task automatic t_clk;
      logic [7:0] cfg [6];
      int ex [6];
      logic [15:0] t0, d;
      cfg = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h01, 8'h02};
      ex = '{67, 33, 17, 8, 33, 11};
      bus(1'b1, pss_pkg::PSS_OFS_MODE, 32'h1);
      bus(1'b1, pss_pkg::PSS_OFS_PR, 32'hffff);
      bus(1'b1, pss_pkg::PSS_OFS_PRS, 32'h1);
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, pss_pkg::PSS_OFS_CLK, {24'h0, cfg[i]});
         pin(4);
         bus(1'b0, pss_pkg::PSS_OFS_STAT, 32'h0);
         t0 = rd[23:8];
         repeat (64) @(posedge ref_clk);
         bus(1'b0, pss_pkg::PSS_OFS_STAT, 32'h0);
         d = rd[23:8] - t0;
         chk(32'(d >= 16'(ex[i] - 1) && d <= 16'(ex[i] + 1)), 32'h1);
      end
      bus(1'b1, pss_pkg::PSS_OFS_CLK, 32'h0);
   endtask
   task automatic t_per;
      bus(1'b1, pss_pkg::PSS_OFS_PRS, 32'h9f);
      for (int k = 0; k < 6; k++) begin
         if (k == 5) bus(1'b1, pss_pkg::PSS_OFS_PRS, 32'h1);
         pin(40);
         event_input_pin <= (k == 0 || k == 5);
         comparator_sync_out <= (k > 0 && k < 5) ? 4'(1 << (k - 1)) : 4'h0;
         pin(3);
         event_input_pin <= 1'b0;
         comparator_sync_out <= 4'h0;
         bus(1'b0, pss_pkg::PSS_OFS_STAT, 32'h0);
         chk(32'(rd[23:8] < 16'd10), 32'(k < 5));
      end
   endtask
   task automatic t_skip;
      bus(1'b1, pss_pkg::PSS_OFS_PR, 32'd20);
      bus(1'b1, pss_pkg::PSS_OFS_PH, 32'd5);
      bus(1'b1, pss_pkg::PSS_OFS_DB, 32'h0808);
      // restart the time base below the new period
      bus(1'b1, pss_pkg::PSS_OFS_PRS, 32'h81);
      event_input_pin <= 1'b1;
      pin(3);
      event_input_pin <= 1'b0;
      s = 1'b0;
      repeat (60) begin
         @(negedge ref_clk);
         if (pwm_out[0] === 1'b1) s = 1'b1;
      end
      chk(32'(s), 32'h0);
      rise_src <= 4'h2;
      wait_pin(0, 1'b1);
      chk({27'h0, pwm_out[5:1]}, 32'h0);
      rise_src <= 4'h0;
      fall_src <= 4'h4;
      wait_pin(0, 1'b0);
      fall_src <= 4'h0;
   endtask
   task automatic t_bridge;
      bus(1'b1, pss_pkg::PSS_OFS_MODE, 32'h2);
      pin(40);
      chk({29'h0, pwm_out[3:1]}, 32'h4);
      fall_src <= 4'h1;
      wait_pin(0, 1'b0);
      fall_src <= 4'h0;
      wait_pin(0, 1'b1);
      bus(1'b1, pss_pkg::PSS_OFS_MODE, 32'h3);
      pin(6);
      chk({31'h0, pwm_out[2]}, 32'h0);
      pin(30);
      chk({29'h0, pwm_out[3:2], pwm_out[0]}, 32'h2);
      wait_pin(1, 1'b1);
      bus(1'b1, pss_pkg::PSS_OFS_MODE, 32'h2);
      pin(6);
      chk({31'h0, pwm_out[3]}, 32'h0);
      pin(30);
      chk({31'h0, pwm_out[3]}, 32'h1);
   endtask
   task automatic t_sd;
      bus(1'b1, pss_pkg::PSS_OFS_ASDS, 32'h1);
      bus(1'b1, pss_pkg::PSS_OFS_ASDL, 32'h5);
      n = irqs;
      bus(1'b1, pss_pkg::PSS_OFS_ASDC, 32'h80);
      shutdown_src <= 4'h1;
      pin(10);
      chk(32'(irqs - n), 32'h1);
      chk({28'h0, pwm_out[3:0]}, 32'h5);
      bus(1'b1, pss_pkg::PSS_OFS_ASDC, 32'h80);
      bus(1'b0, pss_pkg::PSS_OFS_ASDC, 32'h0);
      chk({31'h0, rd[6]}, 32'h1);
      shutdown_src <= 4'h0;
      pin(10);
      bus(1'b0, pss_pkg::PSS_OFS_ASDC, 32'h0);
      chk({31'h0, rd[6]}, 32'h1);
      bus(1'b1, pss_pkg::PSS_OFS_ASDC, 32'h80);
      pin(40);
      chk({29'h0, pwm_out[3:1]}, 32'h4);
      bus(1'b1, pss_pkg::PSS_OFS_ASDC, 32'h90);
      shutdown_src <= 4'h1;
      pin(8);
      shutdown_src <= 4'h0;
      pin(10);
      bus(1'b0, pss_pkg::PSS_OFS_ASDC, 32'h0);
      chk({31'h0, rd[6]}, 32'h0);
      pin(40);
      chk({29'h0, pwm_out[3:1]}, 32'h4);
      n = irqs;
      bus(1'b1, pss_pkg::PSS_OFS_ASDC, 32'hc0);
      pin(4);
      chk(32'(irqs - n), 32'h1);
      chk({28'h0, pwm_out[3:0]}, 32'h5);
      bus(1'b1, pss_pkg::PSS_OFS_ASDC, 32'ha0);
      n = irqs;
      pin(4);
      chk({28'h0, pwm_out[3:0]}, 32'h5);
      chk(32'(irqs - n), 32'h0);
      bus(1'b1, pss_pkg::PSS_OFS_ASDC, 32'h0);
      shutdown_src <= 4'h1;
      pin(40);
      chk(32'(irqs - n), 32'h0);
      chk({31'h0, pwm_out[3]}, 32'h1);
      shutdown_src <= 4'h0;
   endtask
   // ==========================================
   // run control
   task automatic end_sim;
      $display("checks=%0d fails=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      #400us;
      fails++;
      end_sim;
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_regs;
      t_clk;
      t_per;
      t_skip;
      t_bridge;
      t_sd;
      end_sim;
   end
endmodule // tb_top
